/* rsp_frontend.sv */
// serial port, clock output gate and interrupt pin of the rtc front end
//
// Summary of operation
// - serial access is accepted only while chip enable is high.
// - data output is high impedance whenever chip enable is low.
// - while deselected, shift clock and data input change nothing.
// - write bits are sampled on each rising shift clock edge.
// - read bits change on the data output after each falling edge.
// - gate high drives the clock pin with the 32.768 kHz oscillator.
// - gate low stops the clock pin and leaves it high impedance.
// - events pull one active-low open-drain interrupt pin low, never high.
// - transfer opens with a mode code; 9,A,B read and 1,2,3 write banks.
// - same-named registers of banks one and two share one storage.
`timescale 1ns/1ps
module rsp_frontend (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic sclk_i,
   input wire logic serial_data_in_i,
   input wire logic clock_out_gate_i,
   input wire logic osc_32k_i,
   input wire logic alarm_evt_i,
   input wire logic timer_evt_i,
   input wire logic update_evt_i,
   input wire logic [7:0] reg_rdata_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic clock_out_pin_o,
   output logic clock_out_pin_oe_o,
   output logic int_n_o,
   output logic int_n_oe_o,
   output rsp_pkg::rsp_req_s reg_req_o
);
   import rsp_pkg::*;

   rsp_state_e state_ff;
   rsp_mode_s mode_ff;
   logic [2:0] bitcnt_ff;
   logic [7:0] shift_ff;
   logic [3:0] addr_ff;
   logic [7:0] wdata_ff;
   logic wr_ff;
   logic fetch_ff;
   logic [7:0] rdsr_ff;
   logic sdo_ff;
   logic sdo_oe_ff;
   logic sclk_ff;
   logic clock_out_pin_ff;
   logic clock_out_pin_oe_ff;
   logic evt_ff;
   logic sclk_rise;
   logic sclk_fall;
   logic [7:0] nxt_shift;
   rsp_mode_s nxt_mode;

   // edges count only while selected
   assign sclk_rise = ce_i & sclk_i & ~sclk_ff;
   assign sclk_fall = ce_i & ~sclk_i & sclk_ff;
   assign nxt_shift = {shift_ff[6:0], serial_data_in_i};
   assign nxt_mode = rsp_decode(nxt_shift[3:0]);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_ff <= 1'b0;
      end else begin
         sclk_ff <= sclk_i;
      end
   end

   // transfer sequencing
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= RSP_MODE;
         bitcnt_ff <= BITCNT_RST;
         shift_ff <= DATA_RST;
         mode_ff <= MODE_RST;
      end else if (!ce_i) begin
         state_ff <= RSP_MODE;
         bitcnt_ff <= BITCNT_RST;
         shift_ff <= DATA_RST;
      end else if (sclk_rise) begin
         shift_ff <= nxt_shift;
         bitcnt_ff <= bitcnt_ff + BIT_STEP;
         case (state_ff)
            RSP_MODE: begin
               if (bitcnt_ff == MODE_LAST_BIT) begin
                  bitcnt_ff <= BITCNT_RST;
                  mode_ff <= nxt_mode;
                  state_ff <= nxt_mode.valid ? RSP_ADDR : RSP_SKIP;
               end
            end
            RSP_ADDR: begin
               if (bitcnt_ff == ADDR_LAST_BIT) begin
                  bitcnt_ff <= BITCNT_RST;
                  state_ff <= mode_ff.read ? RSP_RDATA : RSP_WDATA;
               end
            end
            RSP_WDATA: state_ff <= RSP_WDATA;
            RSP_RDATA: state_ff <= RSP_RDATA;
            RSP_SKIP: state_ff <= RSP_SKIP;
            default: state_ff <= RSP_SKIP;
         endcase
      end
   end

   // register address, auto-incremented per byte
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_ff <= ADDR_RST;
      end else if (sclk_rise && state_ff == RSP_ADDR && bitcnt_ff == ADDR_LAST_BIT) begin
         addr_ff <= nxt_shift[3:0];
      end else if (wr_ff) begin
         addr_ff <= addr_ff + ADDR_STEP;
      end else if (sclk_rise && state_ff == RSP_RDATA && bitcnt_ff == DATA_LAST_BIT) begin
         addr_ff <= addr_ff + ADDR_STEP;
      end
   end

   // write strobe after each full byte
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ff <= 1'b0;
         wdata_ff <= DATA_RST;
      end else begin
         wr_ff <= sclk_rise && state_ff == RSP_WDATA && bitcnt_ff == DATA_LAST_BIT;
         if (sclk_rise && state_ff == RSP_WDATA && bitcnt_ff == DATA_LAST_BIT) begin
            wdata_ff <= nxt_shift;
         end
      end
   end

   // read fetch and output shifter
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fetch_ff <= 1'b0;
         rdsr_ff <= DATA_RST;
         sdo_ff <= 1'b0;
         sdo_oe_ff <= 1'b0;
      end else begin
         fetch_ff <= sclk_rise && ((state_ff == RSP_ADDR && bitcnt_ff == ADDR_LAST_BIT
                     && mode_ff.read) || (state_ff == RSP_RDATA && bitcnt_ff == DATA_LAST_BIT));
         if (fetch_ff) begin
            rdsr_ff <= reg_rdata_i;
         end else if (sclk_fall && state_ff == RSP_RDATA) begin
            rdsr_ff <= {rdsr_ff[6:0], 1'b0};
         end
         if (sclk_fall && state_ff == RSP_RDATA) begin
            sdo_ff <= rdsr_ff[7];
         end
         if (!ce_i) begin
            sdo_oe_ff <= 1'b0;
         end else if (sclk_fall && state_ff == RSP_RDATA) begin
            sdo_oe_ff <= 1'b1;
         end
      end
   end

   // clock output gate and interrupt pin
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clock_out_pin_ff <= 1'b0;
         clock_out_pin_oe_ff <= 1'b0;
         evt_ff <= 1'b0;
      end else begin
         clock_out_pin_ff <= osc_32k_i & clock_out_gate_i;
         clock_out_pin_oe_ff <= clock_out_gate_i;
         evt_ff <= alarm_evt_i | timer_evt_i | update_evt_i;
      end
   end

   assign sdo_o = sdo_ff;
   assign sdo_oe_o = sdo_oe_ff & ce_i;
   assign clock_out_pin_o = clock_out_pin_ff;
   assign clock_out_pin_oe_o = clock_out_pin_oe_ff;
   assign int_n_o = 1'b0;
   assign int_n_oe_o = evt_ff;
   assign reg_req_o = '{wr: wr_ff, rd: fetch_ff,
                        ext_bank: mode_ff.bank == BANK3,
                        alt_view: mode_ff.bank == BANK2,
                        addr: addr_ff, wdata: wdata_ff};

   sequence s_rise;
      sclk_rise;
   endsequence

   sequence s_deselected;
      !ce_i ##1 !ce_i;
   endsequence

   property p_sdo_hiz;
      @(posedge mclk_i) disable iff (!rst_n_i) !ce_i |-> !sdo_oe_o ##1 !sdo_oe_o;
   endproperty
   a_sdo_hiz: assert property (p_sdo_hiz) else $error("data output driven while deselected");

   property p_desel_quiet;
      @(posedge mclk_i) disable iff (!rst_n_i) s_deselected |-> !reg_req_o.wr && !reg_req_o.rd;
   endproperty
   a_desel_quiet: assert property (p_desel_quiet) else $error("register access while deselected");

   property p_wr_after_rise;
      @(posedge mclk_i) disable iff (!rst_n_i)
         reg_req_o.wr |-> $past(sclk_rise) && $past(ce_i) && reg_req_o.wdata == $past(nxt_shift);
   endproperty
   a_wr_after_rise: assert property (p_wr_after_rise) else $error("write not tied to rising edge");

   property p_sdo_on_fall;
      @(posedge mclk_i) disable iff (!rst_n_i) $changed(sdo_ff) |-> $past(sclk_fall);
   endproperty
   a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("read bit changed off falling edge");

   property p_clock_out_pin_on;
      @(posedge mclk_i) disable iff (!rst_n_i)
         clock_out_gate_i |=> clock_out_pin_oe_o && clock_out_pin_o == $past(osc_32k_i);
   endproperty
   a_clock_out_pin_on: assert property (p_clock_out_pin_on) else $error("clock output not following oscillator");

   property p_clock_out_pin_off;
      @(posedge mclk_i) disable iff (!rst_n_i) !clock_out_gate_i |=> !clock_out_pin_oe_o;
   endproperty
   a_clock_out_pin_off: assert property (p_clock_out_pin_off) else $error("clock output driven while gated off");

   property p_int_od;
      @(posedge mclk_i) disable iff (!rst_n_i)
         (alarm_evt_i || timer_evt_i || update_evt_i) |=> int_n_oe_o && !int_n_o;
   endproperty
   a_int_od: assert property (p_int_od) else $error("interrupt not pulled low on event");

   property p_bad_mode;
      @(posedge mclk_i) disable iff (!rst_n_i)
         (s_rise ##0 (state_ff == RSP_MODE && bitcnt_ff == MODE_LAST_BIT
          && !nxt_mode.valid)) |=> state_ff == RSP_SKIP && !reg_req_o.wr;
   endproperty
   a_bad_mode: assert property (p_bad_mode) else $error("unknown mode code not ignored");

   property p_bank_view;
      @(posedge mclk_i) disable iff (!rst_n_i)
         reg_req_o.wr |-> !(reg_req_o.ext_bank && reg_req_o.alt_view);
   endproperty
   a_bank_view: assert property (p_bank_view) else $error("bank flags both set");

   property p_ce_fall;
      @(posedge mclk_i) disable iff (!rst_n_i)
         $fell(ce_i) |=> state_ff == RSP_MODE && bitcnt_ff == BITCNT_RST;
   endproperty
   a_ce_fall: assert property (p_ce_fall) else $error("transfer not ended by deselect");

   property p_drive_late;
      @(posedge mclk_i) disable iff (!rst_n_i) sdo_oe_o |-> state_ff == RSP_RDATA && ce_i;
   endproperty
   a_drive_late: assert property (p_drive_late) else $error("data output driven too early");
endmodule : rsp_frontend

/* rsp_frontend_tb.sv */
// self-checking bench for the rtc serial port front end
`timescale 1ns/1ps
module rsp_frontend_tb;
   import rsp_pkg::*;
   typedef struct {
      logic [3:0] mode;
      logic [3:0] addr;
      logic [7:0] data;
      int pulses;
      logic [3:0] flags;
   } rsp_row_s;
   logic mclk_i, rst_n_i, gate, osc, alarm, timer, upd, ce, sclk, din;
   logic sdo, sdo_oe, clk_pin, clk_oe, int_n, int_oe;
   logic [7:0] rdata, rd_byte;
   rsp_req_s req, seen;
   int pulses, checks, err_total;
   rsp_row_s rows [8] = '{
      '{MODE_WR_B1, 4'h5, 8'hA5, 1, 4'b1000},
      '{MODE_WR_B2, 4'h5, 8'h3C, 1, 4'b1001},
      '{MODE_WR_B3, 4'hF, 8'h81, 1, 4'b1010},
      '{MODE_RD_B1, 4'h2, 8'h5A, 2, 4'b0100},
      '{MODE_RD_B2, 4'h2, 8'hC3, 2, 4'b0101},
      '{MODE_RD_B3, 4'h0, 8'h7E, 2, 4'b0110},
      '{4'h5, 4'h1, 8'hFF, 0, 4'b0000},
      '{4'hF, 4'h1, 8'h00, 0, 4'b0000}};

   rsp_frontend DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .sclk_i(sclk),
      .serial_data_in_i(din), .clock_out_gate_i(gate), .osc_32k_i(osc),
      .alarm_evt_i(alarm), .timer_evt_i(timer), .update_evt_i(upd), .reg_rdata_i(rdata),
      .sdo_o(sdo), .sdo_oe_o(sdo_oe), .clock_out_pin_o(clk_pin),
      .clock_out_pin_oe_o(clk_oe), .int_n_o(int_n), .int_n_oe_o(int_oe), .reg_req_o(req));
   // released data line reads inverted so a read while undriven is caught
   rsp_host_model HOST (.mclk_i(mclk_i), .sdo_i(sdo_oe ? sdo : ~sdo), .ce_o(ce), .sclk_o(sclk),
      .din_o(din), .rd_byte_o(rd_byte));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // first request of a transfer is kept, all are counted
   always @(negedge mclk_i) begin
      if (req.wr || req.rd) begin
         if (pulses == 0) seen = req;
         pulses++;
      end
   end
   task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   task automatic xfer(input rsp_row_s r, input int nbits);
      HOST.select();
      HOST.shift({r.mode, r.addr}, 8);
      check("oe_addr", {15'h0, sdo_oe}, 16'h0);
      HOST.shift(r.data, nbits);
      HOST.deselect();
      check("oe_idle", {15'h0, sdo_oe}, 16'h0);
   endtask : xfer
   initial begin
      #1_000_000;
      err_total++;
      complete_run();
   end
   initial begin
      rst_n_i = 1'b0;
      {gate, osc, alarm, timer, upd} = 5'h0;
      rdata = 8'h00;
      pulses = 0;
      repeat (2) @(posedge mclk_i);
      check("rst_out", {sdo_oe, clk_oe, int_oe, 13'h0}, 16'h0);
      check("rst_req", req, 16'h0);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      foreach (rows[i]) begin
         rdata <= rows[i].data;
         pulses = 0;
         xfer(rows[i], 8);
         check("pulses", 16'(pulses), 16'(rows[i].pulses));
         if (rows[i].pulses > 0)
            check("req", {seen.wr, seen.rd, seen.ext_bank, seen.alt_view, seen.addr, 8'h00},
               {rows[i].flags, rows[i].addr, 8'h00});
         if (rows[i].flags[3])
            check("wdata", {8'h00, seen.wdata}, {8'h00, rows[i].data});
         if (rows[i].flags[2])
            check("rbyte", {8'h00, rd_byte}, {8'h00, rows[i].data});
         $display("test row %0d done", i);
      end
      pulses = 0;
      HOST.noise();
      xfer(rows[1], 4);
      HOST.noise();
      xfer(rows[0], 8);
      check("abort", {4'(pulses), seen.addr, seen.wdata}, 16'h15A5);
      $display("test abort done");
      gate <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         osc <= i[0];
         repeat (2) @(posedge mclk_i);
         check("clock_out_pin", {14'h0, clk_oe, clk_pin}, {14'h0, 1'b1, i[0]});
      end
      gate <= 1'b0;
      repeat (2) @(posedge mclk_i);
      check("clock_out_pin_off", {14'h0, clk_oe, clk_pin}, 16'h0);
      $display("test clock out done");
      for (int i = 0; i < 3; i++) begin
         {alarm, timer, upd} <= 3'b001 << i;
         repeat (2) @(posedge mclk_i);
         check("int_on", {14'h0, int_n, int_oe}, 16'h1);
         {alarm, timer, upd} <= 3'b000;
         repeat (2) @(posedge mclk_i);
         check("int_off", {14'h0, int_n, int_oe}, 16'h0);
      end
      $display("test interrupt done");
      // reset in the middle of a write, then a clean transfer
      pulses = 0;
      HOST.select();
      HOST.shift({MODE_WR_B3, 4'h7}, 8);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      check("mid_rst", req, 16'h0);
      check("mid_oe", {15'h0, sdo_oe}, 16'h0);
      HOST.deselect();
      rst_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      xfer(rows[0], 8);
      check("after_rst", {4'(pulses), seen.addr, seen.wdata}, 16'h15A5);
      $display("test reset done");
      complete_run();
   end
endmodule : rsp_frontend_tb

/* rsp_host_model.sv */
// host model driving the rtc serial port
`timescale 1ns/1ps
module rsp_host_model (
   input wire logic mclk_i,
   input wire logic sdo_i,
   output logic ce_o,
   output logic sclk_o,
   output logic din_o,
   output logic [7:0] rd_byte_o
);
   initial begin
      ce_o = 1'b0;
      sclk_o = 1'b0;
      din_o = 1'b0;
      rd_byte_o = 8'h00;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : wait_clk
   task automatic select();
      ce_o <= 1'b1;
      wait_clk(3);
   endtask : select
   // msb first, data changes only while sclk low
   task automatic shift(input logic [7:0] val, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         sclk_o <= 1'b0;
         din_o <= val[i];
         wait_clk(3);
         sclk_o <= 1'b1;
         rd_byte_o <= {rd_byte_o[6:0], sdo_i};
         wait_clk(3);
      end
   endtask : shift
   task automatic deselect();
      sclk_o <= 1'b0;
      wait_clk(3);
      ce_o <= 1'b0;
      din_o <= ~din_o;
      wait_clk(3);
   endtask : deselect
   // activity while deselected
   task automatic noise();
      for (int i = 0; i < 4; i++) begin
         sclk_o <= ~sclk_o;
         din_o <= ~din_o;
         wait_clk(3);
      end
   endtask : noise
endmodule : rsp_host_model

/* rsp_pkg.sv */
// constants, types and mode decoding for the rtc serial port front end
package rsp_pkg;
   localparam logic [3:0] MODE_RD_B1 = 4'h9;
   localparam logic [3:0] MODE_RD_B2 = 4'hA;
   localparam logic [3:0] MODE_RD_B3 = 4'hB;
   localparam logic [3:0] MODE_WR_B1 = 4'h1;
   localparam logic [3:0] MODE_WR_B2 = 4'h2;
   localparam logic [3:0] MODE_WR_B3 = 4'h3;
   localparam logic [1:0] BANK_NONE = 2'h0;
   localparam logic [1:0] BANK1 = 2'h1;
   localparam logic [1:0] BANK2 = 2'h2;
   localparam logic [1:0] BANK3 = 2'h3;
   localparam logic [2:0] MODE_LAST_BIT = 3'h3;
   localparam logic [2:0] ADDR_LAST_BIT = 3'h3;
   localparam logic [2:0] DATA_LAST_BIT = 3'h7;
   localparam logic [2:0] BITCNT_RST = 3'h0;
   localparam logic [3:0] ADDR_RST = 4'h0;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [3:0] ADDR_STEP = 4'h1;
   localparam logic [2:0] BIT_STEP = 3'h1;

   typedef enum logic [2:0] {
      RSP_MODE  = 3'b000,
      RSP_ADDR  = 3'b001,
      RSP_WDATA = 3'b011,
      RSP_RDATA = 3'b101,
      RSP_SKIP  = 3'b100
   } rsp_state_e;

   typedef struct packed {
      logic valid;
      logic read;
      logic [1:0] bank;
   } rsp_mode_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic ext_bank;
      logic alt_view;
      logic [3:0] addr;
      logic [7:0] wdata;
   } rsp_req_s;

   localparam rsp_mode_s MODE_RST = '{valid: 1'b0, read: 1'b0, bank: BANK_NONE};

   function automatic rsp_mode_s rsp_decode(input logic [3:0] code);
      rsp_mode_s m;
      m = MODE_RST;
      case (code)
         MODE_RD_B1: m = '{valid: 1'b1, read: 1'b1, bank: BANK1};
         MODE_RD_B2: m = '{valid: 1'b1, read: 1'b1, bank: BANK2};
         MODE_RD_B3: m = '{valid: 1'b1, read: 1'b1, bank: BANK3};
         MODE_WR_B1: m = '{valid: 1'b1, read: 1'b0, bank: BANK1};
         MODE_WR_B2: m = '{valid: 1'b1, read: 1'b0, bank: BANK2};
         MODE_WR_B3: m = '{valid: 1'b1, read: 1'b0, bank: BANK3};
         default: m = MODE_RST;
      endcase
      return m;
   endfunction : rsp_decode
endpackage : rsp_pkg
